// ---- hw/led_cfg_pkg.sv ----
// Shared constants and types of the LED driver configuration register bank
package led_cfg_pkg;

  // ***************************************************************
  // Sizes
  // ***************************************************************
  localparam int NUM_MODULES = 12;
  localparam int IDX_W       = 4;

  // ***************************************************************
  // Register offsets
  // ***************************************************************
  localparam logic [7:0] ADDR_RUN       = 8'h00;
  localparam logic [7:0] ADDR_OPTS      = 8'h01;
  localparam logic [7:0] ADDR_SEL_LO    = 8'h02;
  localparam logic [7:0] ADDR_SEL_HI    = 8'h03;
  localparam logic [7:0] ADDR_GRP_INT   = 8'h04;
  localparam logic [7:0] ADDR_MIX_A     = 8'h05;
  localparam logic [7:0] ADDR_MIX_B     = 8'h06;
  localparam logic [7:0] ADDR_MIX_C     = 8'h07;
  localparam logic [7:0] ADDR_INT_FIRST = 8'h08;
  localparam logic [7:0] ADDR_INT_LAST  = 8'h13;

  // ***************************************************************
  // Reset values, writable masks and field positions
  // ***************************************************************
  localparam logic [7:0] RST_RUN     = 8'h00;
  localparam logic [7:0] RST_OPTS    = 8'hae;
  localparam logic [7:0] RST_SEL     = 8'h00;
  localparam logic [7:0] RST_GRP_INT = 8'hff;
  localparam logic [7:0] RST_MIX     = 8'h00;
  localparam logic [7:0] RST_INT     = 8'hff;
  localparam logic [7:0] MASK_RUN    = 8'h40;
  localparam logic [7:0] MASK_OPTS   = 8'hb7;
  localparam logic [7:0] OPTS_ONES   = 8'h08;
  localparam logic [7:0] MASK_SEL_HI = 8'h0f;
  localparam int BIT_CHIP_EN = 6;
  localparam int BIT_STAGGER = 7;
  localparam int BIT_LOG     = 5;
  localparam int BIT_PSAVE   = 4;
  localparam int BIT_DITHER  = 2;
  localparam int BIT_HICUR   = 1;
  localparam int BIT_OFF     = 0;

  // ***************************************************************
  // Timing: PWM period at the reference clock rate
  // ***************************************************************
  localparam int CLK_HZ         = 25_000_000;
  localparam int PWM_RATE_HZ    = 30_000;
  localparam int PWM_PERIOD_CYC = CLK_HZ / PWM_RATE_HZ;
  localparam int CNT_W          = 10;

  // Full register image
  typedef struct packed {
    logic [7:0]                  run;
    logic [7:0]                  opts;
    logic [7:0]                  sel_lo;
    logic [7:0]                  sel_hi;
    logic [7:0]                  grp_int;
    logic [7:0]                  mix_a;
    logic [7:0]                  mix_b;
    logic [7:0]                  mix_c;
    logic [NUM_MODULES-1:0][7:0] intens;
  } cfg_t;

  localparam cfg_t CFG_RESET = '{RST_RUN, RST_OPTS, RST_SEL, RST_SEL, RST_GRP_INT,
                                 RST_MIX, RST_MIX, RST_MIX, {NUM_MODULES{RST_INT}}};

endpackage : led_cfg_pkg

// ---- hw/pwm_period_tick.sv ----
// Divider that marks the start of each PWM period with a one-cycle enable
module pwm_period_tick
(
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  // Period enable
  output logic      period_start
);
  import led_cfg_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             tick;
  } tick_state_t;

  tick_state_t state_reg;
  tick_state_t state_next;

  // Count one period and pulse on wrap
  always_comb
  begin
    state_next = state_reg;
    state_next.tick = 1'b0;
    if (state_reg.cnt == CNT_W'(PWM_PERIOD_CYC - 1))
    begin
      state_next.cnt  = '0;
      state_next.tick = 1'b1;
    end
    else
    begin
      state_next.cnt = state_reg.cnt + CNT_W'(1);
    end
  end

  // State register
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign period_start = state_reg.tick;

  AST_TICK_AT_WRAP: assert property (@(posedge ref_clk) disable iff (sys_rst)
    period_start |-> state_reg.cnt == '0 ##1 !period_start)
    else $error("period tick not at counter wrap");

endmodule : pwm_period_tick

// ---- hw/module_source_select.sv ----
// Per-module choice between the module's own intensity and the shared group one
module module_source_select
(
  // Clock and reset
  input  wire logic                                    ref_clk,
  input  wire logic                                    sys_rst,
  // Applied settings
  input  wire logic [led_cfg_pkg::NUM_MODULES-1:0]      group_sel,
  input  wire logic [7:0]                              grp_int,
  input  wire logic [led_cfg_pkg::NUM_MODULES-1:0][7:0] own_int,
  // Intensity handed to each module's PWM
  output logic [led_cfg_pkg::NUM_MODULES-1:0][7:0]      drive_int
);
  import led_cfg_pkg::*;

  typedef struct packed {
    logic [NUM_MODULES-1:0][7:0] drive;
  } sel_state_t;

  sel_state_t state_reg;
  sel_state_t state_next;

  // Bank-mode modules follow the group value, the rest their own
  always_comb
  begin
    state_next = state_reg;
    for (int i = 0; i < NUM_MODULES; i++)
      state_next.drive[i] = group_sel[i] ? grp_int : own_int[i];
  end

  // State register
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      state_reg <= '{drive: {NUM_MODULES{RST_INT}}};
    else
      state_reg <= state_next;
  end

  assign drive_int = state_reg.drive;

  AST_OWN_SOURCE: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !group_sel[0] |=> drive_int[0] == $past(own_int[0]))
    else $error("independent module not on its own intensity");

  AST_GROUP_SOURCE: assert property (@(posedge ref_clk) disable iff (sys_rst)
    group_sel[NUM_MODULES-1] |=> drive_int[NUM_MODULES-1] == $past(grp_int))
    else $error("bank module not on group intensity");

endmodule : module_source_select

// ---- hw/led_config_regs.sv ----
// Configuration register bank of a 36-channel RGB LED driver
module led_config_regs
(
  // Clock and reset
  input  wire logic                                    ref_clk,
  input  wire logic                                    sys_rst,
  // Register access from the serial control interface
  input  wire logic                                    reg_wr_en,
  input  wire logic                                    reg_rd_en,
  input  wire logic [7:0]                              reg_addr,
  input  wire logic [7:0]                              reg_wr_data,
  output logic [7:0]                                   reg_rd_data,
  output logic                                         reg_rd_valid,
  // Device controls
  output logic                                         chip_enable,
  output logic                                         all_outputs_off,
  output logic                                         phase_stagger_en,
  output logic                                         log_scale_en,
  output logic                                         power_save_en,
  output logic                                         dither_en,
  output logic                                         high_current_sel,
  // Colour and intensity settings
  output logic [led_cfg_pkg::NUM_MODULES-1:0]           module_group_select,
  output logic [7:0]                                   group_a_mix,
  output logic [7:0]                                   group_b_mix,
  output logic [7:0]                                   group_c_mix,
  output logic [led_cfg_pkg::NUM_MODULES-1:0][7:0]      module_drive_intensity,
  // PWM period marker
  output logic                                         period_start
);
  import led_cfg_pkg::*;

  // ***************************************************************
  // State
  // ***************************************************************

  // Live copy is what the host sees; applied copy feeds the datapath
  typedef struct packed {
    cfg_t       live;
    cfg_t       act;
    logic [7:0] rd_data;
    logic       rd_valid;
  } regs_state_t;

  regs_state_t state_reg;
  regs_state_t state_next;
  logic        tick;

  // ***************************************************************
  // Decode helpers
  // ***************************************************************

  // True for any offset of the bank
  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a <= ADDR_INT_LAST);
  endfunction : addr_mapped

  // Per-module intensity index for offsets 0x08..0x13
  function automatic logic [IDX_W-1:0] int_index(input logic [7:0] a);
    logic [7:0] d;
    d = a - ADDR_INT_FIRST;
    int_index = d[IDX_W-1:0];
  endfunction : int_index

  // Read view of one register; reserved bits as fixed values
  function automatic logic [7:0] read_word(input cfg_t c, input logic [7:0] a);
    logic [7:0] w;
    w = 8'h00;
    case (a)
      ADDR_RUN:     w = c.run & MASK_RUN;
      ADDR_OPTS:    w = (c.opts & MASK_OPTS) | OPTS_ONES;
      ADDR_SEL_LO:  w = c.sel_lo;
      ADDR_SEL_HI:  w = c.sel_hi & MASK_SEL_HI;
      ADDR_GRP_INT: w = c.grp_int;
      ADDR_MIX_A:   w = c.mix_a;
      ADDR_MIX_B:   w = c.mix_b;
      ADDR_MIX_C:   w = c.mix_c;
      default:
      begin
        if (a >= ADDR_INT_FIRST && a <= ADDR_INT_LAST)
          w = c.intens[int_index(a)];
      end
    endcase
    read_word = w;
  endfunction : read_word

  // Store one byte; reserved positions keep their fixed value
  function automatic cfg_t write_word(input cfg_t c, input logic [7:0] a,
                                      input logic [7:0] d);
    cfg_t n;
    n = c;
    case (a)
      ADDR_RUN:     n.run     = d & MASK_RUN;
      ADDR_OPTS:    n.opts    = (d & MASK_OPTS) | OPTS_ONES;
      ADDR_SEL_LO:  n.sel_lo  = d;
      ADDR_SEL_HI:  n.sel_hi  = d & MASK_SEL_HI;
      ADDR_GRP_INT: n.grp_int = d;
      ADDR_MIX_A:   n.mix_a   = d;
      ADDR_MIX_B:   n.mix_b   = d;
      ADDR_MIX_C:   n.mix_c   = d;
      default:
      begin
        if (a >= ADDR_INT_FIRST && a <= ADDR_INT_LAST)
          n.intens[int_index(a)] = d;
      end
    endcase
    write_word = n;
  endfunction : write_word

  // ***************************************************************
  // Register access and apply
  // ***************************************************************

  // A read in the same cycle as a write to the same offset sees the old value
  always_comb
  begin
    state_next          = state_reg;
    state_next.rd_valid = reg_rd_en;
    if (reg_rd_en)
      state_next.rd_data = addr_mapped(reg_addr) ? read_word(state_reg.live, reg_addr) : 8'h00;
    if (reg_wr_en && addr_mapped(reg_addr))
      state_next.live = write_word(state_reg.live, reg_addr, reg_wr_data);
    // Applying only at a period boundary avoids a torn PWM cycle
    if (tick)
      state_next.act = state_reg.live;
  end

  // State register
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      state_reg.live     <= CFG_RESET;
      state_reg.act      <= CFG_RESET;
      state_reg.rd_data  <= 8'h00;
      state_reg.rd_valid <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ***************************************************************
  // Submodules
  // ***************************************************************

  // PWM period marker
  pwm_period_tick u_tick
  (
    .ref_clk      (ref_clk),
    .sys_rst      (sys_rst),
    .period_start (tick)
  );

  // Per-module intensity source
  module_source_select u_select
  (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .group_sel (module_group_select),
    .grp_int   (state_reg.act.grp_int),
    .own_int   (state_reg.act.intens),
    .drive_int (module_drive_intensity)
  );

  // ***************************************************************
  // Outputs
  // ***************************************************************

  // Register read answer
  assign reg_rd_data  = state_reg.rd_data;
  assign reg_rd_valid = state_reg.rd_valid;
  assign period_start = tick;

  // Device controls straight from the applied copy
  assign chip_enable      = state_reg.act.run[BIT_CHIP_EN];
  assign all_outputs_off  = state_reg.act.opts[BIT_OFF];
  assign high_current_sel = state_reg.act.opts[BIT_HICUR];
  assign power_save_en    = state_reg.act.opts[BIT_PSAVE];
  assign phase_stagger_en = state_reg.act.opts[BIT_STAGGER];
  assign log_scale_en     = state_reg.act.opts[BIT_LOG];
  assign dither_en        = state_reg.act.opts[BIT_DITHER];

  // Group selection and mixes; the mix byte is a linear fraction of full scale
  assign module_group_select = {state_reg.act.sel_hi[3:0], state_reg.act.sel_lo};
  assign group_a_mix         = state_reg.act.mix_a;
  assign group_b_mix         = state_reg.act.mix_b;
  assign group_c_mix         = state_reg.act.mix_c;

  // ***************************************************************
  // Checks
  // ***************************************************************

  AST_RESET_IMAGE: assert property (@(posedge ref_clk)
    $past(sys_rst) |-> state_reg.live == CFG_RESET && state_reg.act == CFG_RESET)
    else $error("register image not at defaults after reset");

  AST_RESET_OUTPUTS: assert property (@(posedge ref_clk)
    $past(sys_rst) |-> !chip_enable && phase_stagger_en && log_scale_en
      && dither_en && high_current_sel && !power_save_en && !all_outputs_off)
    else $error("control outputs not at defaults after reset");

  AST_RESET_INTENSITY: assert property (@(posedge ref_clk)
    $past(sys_rst) |-> state_reg.live.intens[NUM_MODULES-1] == RST_INT
      && state_reg.live.grp_int == RST_GRP_INT)
    else $error("intensity not at full scale after reset");

  AST_WRITE_READBACK: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (reg_wr_en && !reg_rd_en && reg_addr == ADDR_GRP_INT)
    ##1 (reg_rd_en && !reg_wr_en && reg_addr == ADDR_GRP_INT)
    |=> reg_rd_valid && reg_rd_data == $past(reg_wr_data, 2))
    else $error("group intensity did not read back as written");

  AST_RUN_RESERVED: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (reg_rd_en && reg_addr == ADDR_RUN) |=> (reg_rd_data & ~MASK_RUN) == 8'h00)
    else $error("reserved run-control bits not zero");

  AST_OPTS_FIXED: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (reg_rd_en && reg_addr == ADDR_OPTS) |=> reg_rd_data[3] && !reg_rd_data[6])
    else $error("options reserved bits read wrong");

  AST_SEL_HI_RESERVED: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (reg_rd_en && reg_addr == ADDR_SEL_HI) |=> reg_rd_data[7:4] == 4'h0)
    else $error("upper select bits not zero");

  AST_UNMAPPED_ZERO: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (reg_rd_en && reg_addr > ADDR_INT_LAST) |=> reg_rd_valid && reg_rd_data == 8'h00)
    else $error("unmapped read not zero");

  AST_OFF_APPLIED: assert property (@(posedge ref_clk) disable iff (sys_rst)
    tick |=> all_outputs_off == $past(state_reg.live.opts[BIT_OFF]))
    else $error("output-off not applied at period start");

  AST_OPTIONS_APPLIED: assert property (@(posedge ref_clk) disable iff (sys_rst)
    tick |=> {phase_stagger_en, log_scale_en, dither_en} ==
      $past({state_reg.live.opts[BIT_STAGGER], state_reg.live.opts[BIT_LOG],
             state_reg.live.opts[BIT_DITHER]}))
    else $error("option enables not applied at period start");

  AST_HOLD_MID_PERIOD: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !tick |=> $stable(high_current_sel) && $stable(power_save_en)
      && $stable(chip_enable) && $stable(module_group_select))
    else $error("setting changed inside a PWM period");

  // Read port: valid for one cycle, data held from one read to the next
  AST_RD_VALID_SET: assert property (@(posedge ref_clk) disable iff (sys_rst)
    reg_rd_en |=> reg_rd_valid)
    else $error("read answer missing");

  AST_RD_VALID_PULSE: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !reg_rd_en |=> !reg_rd_valid)
    else $error("read valid longer than one cycle");

  AST_RD_DATA_HOLD: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !reg_rd_en |=> $stable(reg_rd_data))
    else $error("read data changed without a read");

  AST_GRP_INT_READ: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (reg_rd_en && reg_addr == ADDR_GRP_INT) |=> reg_rd_data == $past(state_reg.live.grp_int))
    else $error("group intensity read wrong");

  AST_INT_READ: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (reg_rd_en && reg_addr == ADDR_INT_FIRST) |=> reg_rd_data == $past(state_reg.live.intens[0]))
    else $error("first module intensity read wrong");

  // A write lands only in the addressed register, reserved bits fixed
  AST_NO_WRITE_HOLD: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !reg_wr_en |=> $stable(state_reg.live))
    else $error("register changed without a write");

  AST_UNMAPPED_WRITE: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (reg_wr_en && reg_addr > ADDR_INT_LAST) |=> $stable(state_reg.live))
    else $error("write beyond the map changed a register");

  AST_RUN_WRITE: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (reg_wr_en && reg_addr == ADDR_RUN) |=> state_reg.live.run == ($past(reg_wr_data) & MASK_RUN))
    else $error("run-control write wrong");

  AST_OPTS_WRITE: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (reg_wr_en && reg_addr == ADDR_OPTS) |=> state_reg.live.opts == (($past(reg_wr_data) & MASK_OPTS) | OPTS_ONES))
    else $error("options write wrong");

  AST_SEL_LO_WRITE: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (reg_wr_en && reg_addr == ADDR_SEL_LO) |=> state_reg.live.sel_lo == $past(reg_wr_data))
    else $error("low select write wrong");

  AST_SEL_HI_WRITE: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (reg_wr_en && reg_addr == ADDR_SEL_HI) |=> state_reg.live.sel_hi == {4'h0, $past(reg_wr_data[3:0])})
    else $error("high select write wrong");

  AST_GRP_INT_WRITE: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (reg_wr_en && reg_addr == ADDR_GRP_INT) |=> state_reg.live.grp_int == $past(reg_wr_data))
    else $error("group intensity write wrong");

  AST_MIX_A_WRITE: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (reg_wr_en && reg_addr == ADDR_MIX_A) |=> state_reg.live.mix_a == $past(reg_wr_data))
    else $error("first mix write wrong");

  AST_MIX_B_WRITE: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (reg_wr_en && reg_addr == ADDR_MIX_B) |=> state_reg.live.mix_b == $past(reg_wr_data))
    else $error("second mix write wrong");

  AST_MIX_C_WRITE: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (reg_wr_en && reg_addr == ADDR_MIX_C) |=> state_reg.live.mix_c == $past(reg_wr_data))
    else $error("third mix write wrong");

  AST_INT_LAST_WRITE: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (reg_wr_en && reg_addr == ADDR_INT_LAST) |=> state_reg.live.intens[NUM_MODULES-1] == $past(reg_wr_data))
    else $error("last module intensity write wrong");

  // Every remaining control is copied at the period boundary
  AST_RUN_APPLIED: assert property (@(posedge ref_clk) disable iff (sys_rst)
    tick |=> chip_enable == $past(state_reg.live.run[BIT_CHIP_EN]))
    else $error("chip enable not applied at period start");

  AST_HICUR_APPLIED: assert property (@(posedge ref_clk) disable iff (sys_rst)
    tick |=> high_current_sel == $past(state_reg.live.opts[BIT_HICUR]))
    else $error("current option not applied at period start");

  AST_PSAVE_APPLIED: assert property (@(posedge ref_clk) disable iff (sys_rst)
    tick |=> power_save_en == $past(state_reg.live.opts[BIT_PSAVE]))
    else $error("power save not applied at period start");

  AST_SEL_APPLIED: assert property (@(posedge ref_clk) disable iff (sys_rst)
    tick |=> module_group_select == $past({state_reg.live.sel_hi[3:0], state_reg.live.sel_lo}))
    else $error("group selects not applied at period start");

  AST_MIX_APPLIED: assert property (@(posedge ref_clk) disable iff (sys_rst)
    tick |=> {group_a_mix, group_b_mix, group_c_mix} ==
      $past({state_reg.live.mix_a, state_reg.live.mix_b, state_reg.live.mix_c}))
    else $error("group mixes not applied at period start");

endmodule : led_config_regs

// ---- bench/host_bus_model.sv ----
// Host controller model that drives the byte-wide register port of the bank
module host_bus_model
(
  // Clock
  input  wire logic       ref_clk,
  // Register port towards the device
  output logic            reg_wr_en,
  output logic            reg_rd_en,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wr_data,
  input  wire logic [7:0] reg_rd_data,
  input  wire logic       reg_rd_valid
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle levels at time zero so no strobe starts unknown
  initial
  begin
    reg_wr_en   = 1'b0;
    reg_rd_en   = 1'b0;
    reg_addr    = 8'h00;
    reg_wr_data = 8'h00;
  end

  // One write strobe; released lines show the inverse so stale values never pass
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr_en   <= 1'b1;
    reg_addr    <= a;
    reg_wr_data <= d;
    @(posedge ref_clk);
    reg_wr_en   <= 1'b0;
    reg_addr    <= ~a;
    reg_wr_data <= ~d;
  endtask : write_reg

  // One read strobe; the answer is taken 1 ns after the edge that samples the strobe
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(posedge ref_clk);
    reg_rd_en <= 1'b1;
    reg_addr  <= a;
    @(posedge ref_clk);
    reg_rd_en <= 1'b0;
    reg_addr  <= ~a;
    #1;
    ok = reg_rd_valid;
    d  = reg_rd_data;
  endtask : read_reg

  // Write then read the same offset on the very next cycle; the read sees the new byte
  task automatic write_read(input logic [7:0] a, input logic [7:0] wd, output logic [7:0] d, output logic ok);
    @(posedge ref_clk);
    reg_wr_en   <= 1'b1;
    reg_addr    <= a;
    reg_wr_data <= wd;
    @(posedge ref_clk);
    reg_wr_en   <= 1'b0;
    reg_rd_en   <= 1'b1;
    reg_wr_data <= ~wd;
    @(posedge ref_clk);
    reg_rd_en   <= 1'b0;
    reg_addr    <= ~a;
    #1;
    ok = reg_rd_valid;
    d  = reg_rd_data;
  endtask : write_read

endmodule : host_bus_model

// ---- bench/test_led_config_regs.sv ----
// Self-checking testbench of the LED driver configuration register bank
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin n_fail++; \
  $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end

module test_led_config_regs;
  timeunit 1ns;
  timeprecision 100ps;
  import led_cfg_pkg::*;

  // ***************************************************************
  // Signals and instances
  // ***************************************************************
  logic                        ref_clk = 1'b0;
  logic                        sys_rst = 1'b1;
  logic                        reg_wr_en, reg_rd_en, reg_rd_valid, period_start;
  logic [7:0]                  reg_addr, reg_wr_data, reg_rd_data;
  logic                        chip_enable, all_outputs_off, phase_stagger_en, log_scale_en;
  logic                        power_save_en, dither_en, high_current_sel;
  logic [NUM_MODULES-1:0]      module_group_select;
  logic [7:0]                  group_a_mix, group_b_mix, group_c_mix;
  logic [NUM_MODULES-1:0][7:0] module_drive_intensity;
  logic [7:0]                  exp_reg [0:19];
  int                          n_fail = 0;
  int                          checks = 0;

  led_config_regs i_led_config_regs (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
    .reg_rd_valid(reg_rd_valid), .chip_enable(chip_enable), .all_outputs_off(all_outputs_off),
    .phase_stagger_en(phase_stagger_en), .log_scale_en(log_scale_en), .power_save_en(power_save_en),
    .dither_en(dither_en), .high_current_sel(high_current_sel), .module_group_select(module_group_select),
    .group_a_mix(group_a_mix), .group_b_mix(group_b_mix), .group_c_mix(group_c_mix),
    .module_drive_intensity(module_drive_intensity), .period_start(period_start));

  host_bus_model i_host_bus_model (.ref_clk(ref_clk), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
    .reg_rd_valid(reg_rd_valid));

  // 25 MHz reference clock
  always #20 ref_clk = ~ref_clk;

  // ***************************************************************
  // Reference model and helpers
  // ***************************************************************
  // Reserved bits read as zero, except options bit 3 which always reads one
  function automatic logic [7:0] masked(input int a, input logic [7:0] d);
    case (a)
      0:       return d & 8'h40;
      1:       return (d & 8'hb7) | 8'h08;
      3:       return d & 8'h0f;
      default: return d;
    endcase
  endfunction : masked

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  // Reset is held for eight edges; the model falls back to the defaults
  task automatic reset_dut();
    if (!sys_rst)
      @(posedge ref_clk);
    sys_rst <= 1'b1;
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    for (int a = 0; a < 20; a++)
      exp_reg[a] = (a == 1) ? 8'hae : (a == 4 || a >= 8) ? 8'hff : 8'h00;
  endtask : reset_dut

  // Every mapped offset reads its model value; unmapped offsets 0x14 and 0xff read zero
  task automatic check_reads();
    logic [7:0] d;
    logic       ok;
    for (int a = 0; a < 22; a++)
    begin
      i_host_bus_model.read_reg((a < 20) ? 8'(a) : (a == 20) ? 8'h14 : 8'hff, d, ok);
      `CHK(ok, 1'b1)
      `CHK(d, (a < 20) ? exp_reg[a] : 8'h00)
    end
  endtask : check_reads

  // Controls follow the cycle after period_start, drive intensity one cycle later
  task automatic check_applied();
    logic [7:0] sel;
    int         n;
    wait_period();
    @(posedge ref_clk);
    #1;
    `CHK(chip_enable, exp_reg[0][6])
    `CHK(all_outputs_off, exp_reg[1][0])
    `CHK(high_current_sel, exp_reg[1][1])
    `CHK(power_save_en, exp_reg[1][4])
    `CHK({phase_stagger_en, log_scale_en, dither_en}, {exp_reg[1][7], exp_reg[1][5], exp_reg[1][2]})
    `CHK(module_group_select, {exp_reg[3][3:0], exp_reg[2]})
    `CHK({group_a_mix, group_b_mix, group_c_mix}, {exp_reg[5], exp_reg[6], exp_reg[7]})
    @(posedge ref_clk);
    #1;
    for (int m = 0; m < NUM_MODULES; m++)
    begin
      sel = (m < 8) ? exp_reg[2] >> m : exp_reg[3] >> (m - 8);
      `CHK(module_drive_intensity[m], sel[0] ? exp_reg[4] : exp_reg[8 + m])
    end
    // The next marker follows one full PWM period after the last
    n = 2;
    while (period_start !== 1'b1 && n < 1000)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    `CHK(n, PWM_PERIOD_CYC)
  endtask : check_applied

  // Bounded wait for the period marker; a missing marker ends the run
  task automatic wait_period();
    int n;
    n = 0;
    while (period_start !== 1'b1 && n < 1000)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (n >= 1000)
    begin
      n_fail++;
      $display("mismatch at %0t: no period marker", $time);
      wrap_up();
    end
  endtask : wait_period

  // ***************************************************************
  // Main sequence
  // ***************************************************************
  initial
  begin
    logic [7:0] d;
    logic [7:0] rd;
    logic       ok;
    void'($urandom(46));
    reset_dut();
    check_reads();
    check_applied();
    $display("test defaults done");
    // Random rounds; options bit 0 alternates so both output-off states are seen
    for (int r = 0; r < 3; r++)
    begin
      for (int a = 0; a < 20; a++)
      begin
        d = 8'($urandom);
        if (a == 1)
          d[0] = r[0];
        i_host_bus_model.write_reg(8'(a), d);
        exp_reg[a] = masked(a, d);
      end
      // Writes beyond the map must leave every register untouched
      i_host_bus_model.write_reg(8'h14 + 8'($urandom % 236), 8'($urandom));
      // A read right behind a write to the same offset returns the new byte
      d = 8'($urandom);
      i_host_bus_model.write_read(ADDR_GRP_INT, d, rd, ok);
      exp_reg[4] = d;
      `CHK(ok, 1'b1)
      `CHK(rd, d)
      check_reads();
      wait_period();
      check_applied();
      $display("test random round %0d done", r);
    end
    // Reset in mid-run restores every default
    reset_dut();
    check_reads();
    check_applied();
    $display("test second reset done");
    wrap_up();
  end

endmodule : test_led_config_regs
